// ===== shared/lowpower_fuse_pkg.sv
package lowpower_fuse_pkg;

  // ==========================================================
  // Clock and power-up timing
  localparam int CLK_MHZ         = 50;
  localparam int POWER_UP_NS     = 1000;
  localparam int POWER_UP_CYCLES = (POWER_UP_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_BANK_CFG   = 8'h00;
  localparam logic [7:0] ADDR_PROBE_SEL  = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_USER_STATE = 8'h0C;

  // ==========================================================
  // Sizes
  localparam int NUM_BANKS       = 8;
  localparam int NUM_PADS        = 4;
  localparam int NUM_NETS        = 64;
  localparam int SEL_W           = 6;
  localparam int TILE_SHIFT      = 3;
  localparam int PROBES_PER_TILE = 2;
  localparam int SMALL_PADS      = 2;
  localparam int USER_W          = 8;

  // ==========================================================
  // Field positions
  localparam int PSEL_FIELD_W = 8;
  localparam int PSEL_EN_BIT  = 7;
  localparam int STAT_LOW_POWER = 0;
  localparam int STAT_SEC     = 1;
  localparam int STAT_SET     = 2;
  localparam int STAT_PWRUP   = 3;
  localparam int STAT_LIVE    = 4;
  localparam int STAT_BLOCK   = 8;

  // ==========================================================
  // Reset values
  localparam logic [15:0]       BANK_CFG_RST   = 16'h0000;
  localparam logic [31:0]       PROBE_SEL_RST  = 32'h00000000;
  localparam logic [USER_W-1:0] USER_STATE_RST = 8'h00;

  typedef enum logic [0:0] {
    PWR_INIT = 1'b0,
    PWR_RUN  = 1'b1
  } power_state_e;

  // Tile index of a probe selection
  function automatic logic [SEL_W-TILE_SHIFT-1:0] tile_of(input logic [SEL_W-1:0] sel);
    tile_of = sel[SEL_W-1:TILE_SHIFT];
  endfunction

  // Selection field of one probe pad
  function automatic logic [PSEL_FIELD_W-1:0] psel_field(input logic [31:0] r,
                                                         input int p);
    psel_field = r[p*PSEL_FIELD_W +: PSEL_FIELD_W];
  endfunction

endpackage

// ===== verilog/probe_mux.sv
module probe_mux
  import lowpower_fuse_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [31:0]         probe_sel,
  input  wire logic [NUM_NETS-1:0] internal_nets,
  input  wire logic                security_fuse,
  input  wire logic                small_member,
  output logic [NUM_PADS-1:0]      probe_pads,
  output logic [NUM_PADS-1:0]      pad_live,
  output logic [NUM_PADS-1:0]      pad_blocked
);

  logic [NUM_PADS-1:0] next_pads;
  logic [NUM_PADS-1:0] next_live;
  logic [NUM_PADS-1:0] next_blocked;

  // ==========================================================
  // Pad routing with per-tile limit
  always_comb begin
    logic [PSEL_FIELD_W-1:0] f;
    int                      used;
    f            = '0;
    used         = 0;
    next_pads    = '0;
    next_live    = '0;
    next_blocked = '0;
    for (int p = 0; p < NUM_PADS; p++) begin
      f    = psel_field(probe_sel, p);
      used = 0;
      for (int q = 0; q < p; q++) begin
        if (next_live[q] &&
            tile_of(probe_sel[q*PSEL_FIELD_W +: SEL_W]) == tile_of(f[SEL_W-1:0])) begin
          used++;
        end
      end
      if (f[PSEL_EN_BIT] && !security_fuse) begin
        if (small_member && p >= SMALL_PADS) begin
          next_blocked[p] = 1'b1;
        end else if (used >= PROBES_PER_TILE) begin
          next_blocked[p] = 1'b1;
        end else begin
          next_live[p] = 1'b1;
          next_pads[p] = internal_nets[f[SEL_W-1:0]];
        end
      end
    end
  end

  // Pad registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      probe_pads  <= '0;
      pad_live    <= '0;
      pad_blocked <= '0;
    end else begin
      probe_pads  <= next_pads;
      pad_live    <= next_live;
      pad_blocked <= next_blocked;
    end
  end

  // ==========================================================
  // Checks
  property p_tile_limit;
    @(posedge pclk) disable iff (!presetn)
      (pad_live[0] && pad_live[1] && pad_live[2]) |->
        !(tile_of($past(probe_sel[SEL_W-1:0])) ==
          tile_of($past(probe_sel[PSEL_FIELD_W +: SEL_W])) &&
          tile_of($past(probe_sel[PSEL_FIELD_W +: SEL_W])) ==
          tile_of($past(probe_sel[2*PSEL_FIELD_W +: SEL_W])));
  endproperty
  a_tile_limit: assert property (p_tile_limit) else $error("Three probes from one tile");

  c_blocked: cover property (@(posedge pclk) disable iff (!presetn) |pad_blocked);

endmodule

// ===== verilog/lowpower_fuse_probe_ctrl.sv
// Chosen here: the APB interface to the registers and the register offsets.
module lowpower_fuse_probe_ctrl
  import lowpower_fuse_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 low_power_request,
  input  wire logic                 security_fuse,
  input  wire logic                 power_up_set_fuse,
  input  wire logic                 small_member,
  input  wire logic [USER_W-1:0]    local_clear,
  input  wire logic [USER_W-1:0]    local_preset,
  input  wire logic [NUM_NETS-1:0]  internal_nets,
  output logic [NUM_BANKS-1:0]      bank_output_tristate,
  output logic [NUM_BANKS-1:0]      bank_input_disable,
  output logic                      chip_wide_clear,
  output logic                      chip_wide_preset,
  output logic                      probe_pad_a,
  output logic                      probe_pad_b,
  output logic                      probe_pad_c,
  output logic                      probe_pad_d,
  output logic                      programming_enable,
  output logic                      jtag_public_enable,
  output logic                      jtag_private_enable,
  output logic [USER_W-1:0]         user_state
);

  // ==========================================================
  // Declarations
  logic [15:0]         bank_cfg;
  logic [15:0]         next_bank_cfg;
  logic [31:0]         probe_sel;
  logic [31:0]         next_probe_sel;
  logic [USER_W-1:0]   next_user_state;
  logic [31:0]         next_prdata;
  logic                low_power_active;
  logic                next_low_power_active;
  logic [NUM_BANKS-1:0] next_tristate;
  logic [NUM_BANKS-1:0] next_in_disable;
  power_state_e        pwr_state;
  power_state_e        next_pwr_state;
  logic [7:0]          pwr_count;
  logic [7:0]          next_pwr_count;
  logic                next_clear_net;
  logic                next_preset_net;
  logic                next_prog_enable;
  logic                next_jtag_private;
  logic [NUM_PADS-1:0] probe_pads;
  logic [NUM_PADS-1:0] pad_live;
  logic [NUM_PADS-1:0] pad_blocked;
  logic                wr_access;
  logic                mapped;
  logic [NUM_BANKS-1:0] cfg_tri;
  logic [NUM_BANKS-1:0] cfg_in;

  // ==========================================================
  // APB decode
  // Zero-wait slave; unmapped offsets answer with an error
  assign wr_access = psel && penable && pwrite;
  assign mapped    = (paddr == ADDR_BANK_CFG) || (paddr == ADDR_PROBE_SEL) ||
                     (paddr == ADDR_STATUS) || (paddr == ADDR_USER_STATE);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;

  // Bank configuration split into its two fields
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      cfg_tri[b] = bank_cfg[2*b];
      cfg_in[b]  = bank_cfg[2*b+1];
    end
  end

  // ==========================================================
  // Register file next values
  always_comb begin
    next_bank_cfg  = bank_cfg;
    next_probe_sel = probe_sel;
    next_prdata    = prdata;
    if (wr_access && paddr == ADDR_BANK_CFG) begin
      next_bank_cfg = pwdata[15:0];
    end
    if (wr_access && paddr == ADDR_PROBE_SEL) begin
      next_probe_sel = pwdata;
    end
    // Read data is captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      next_prdata = 32'h00000000;
      unique case (paddr)
        ADDR_BANK_CFG:   next_prdata[15:0] = bank_cfg;
        ADDR_PROBE_SEL:  next_prdata = probe_sel;
        ADDR_STATUS: begin
          next_prdata[STAT_LOW_POWER] = low_power_active;
          next_prdata[STAT_SEC]   = security_fuse;
          next_prdata[STAT_SET]   = power_up_set_fuse;
          next_prdata[STAT_PWRUP] = (pwr_state == PWR_INIT);
          next_prdata[STAT_LIVE +: NUM_PADS]  = pad_live;
          next_prdata[STAT_BLOCK +: NUM_PADS] = pad_blocked;
        end
        ADDR_USER_STATE: next_prdata[USER_W-1:0] = user_state;
        default:         next_prdata = 32'h00000000;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_cfg  <= BANK_CFG_RST;
      probe_sel <= PROBE_SEL_RST;
      prdata    <= 32'h00000000;
    end else begin
      bank_cfg  <= next_bank_cfg;
      probe_sel <= next_probe_sel;
      prdata    <= next_prdata;
    end
  end

  // ==========================================================
  // Low-power mode and bank controls
  // Banks follow the pin in the next cycle, both on entry and exit
  always_comb begin
    next_low_power_active = low_power_request;
    next_tristate   = '0;
    next_in_disable = '0;
    if (low_power_request) begin
      next_tristate   = cfg_tri;
      next_in_disable = cfg_in;
    end
    // Dropping the pin releases every bank at once
  end

  // Low-power flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_active     <= 1'b0;
      bank_output_tristate <= '0;
      bank_input_disable   <= '0;
    end else begin
      low_power_active     <= next_low_power_active;
      bank_output_tristate <= next_tristate;
      bank_input_disable   <= next_in_disable;
    end
  end

  // ==========================================================
  // Power-up sequence and chip-wide nets
  always_comb begin
    next_pwr_state  = pwr_state;
    next_pwr_count  = pwr_count;
    next_clear_net  = 1'b1;
    next_preset_net = 1'b1;
    unique case (pwr_state)
      PWR_INIT: begin
        next_clear_net  = power_up_set_fuse;
        next_preset_net = !power_up_set_fuse;
        if (pwr_count == 8'(POWER_UP_CYCLES - 1)) begin
          next_pwr_state = PWR_RUN;
        end else begin
          next_pwr_count = pwr_count + 8'h01;
        end
      end
      PWR_RUN: begin
        next_clear_net  = 1'b1;
        next_preset_net = 1'b1;
      end
    endcase
  end

  // Power-up flops; reset shows the default clear pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_state        <= PWR_INIT;
      pwr_count        <= 8'h00;
      chip_wide_clear  <= 1'b0;
      chip_wide_preset <= 1'b1;
    end else begin
      pwr_state        <= next_pwr_state;
      pwr_count        <= next_pwr_count;
      chip_wide_clear  <= next_clear_net;
      chip_wide_preset <= next_preset_net;
    end
  end

  // ==========================================================
  // User registers under chip-wide and local control
  // Low-power mode is not an input here, so content is kept
  always_comb begin
    next_user_state = user_state;
    if (pwr_state == PWR_INIT) begin
      next_user_state = power_up_set_fuse ? '1 : '0;
    end else if (wr_access && paddr == ADDR_USER_STATE) begin
      next_user_state = pwdata[USER_W-1:0];
    end
    // Local controls win; clear beats preset
    next_user_state = (next_user_state | local_preset) & ~local_clear;
  end

  // User register flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_state <= USER_STATE_RST;
    end else begin
      user_state <= next_user_state;
    end
  end

  // ==========================================================
  // Security fuse effects
  always_comb begin
    next_prog_enable  = !security_fuse;
    next_jtag_private = !security_fuse;
  end

  // Security flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programming_enable  <= 1'b0;
      jtag_private_enable <= 1'b0;
    end else begin
      programming_enable  <= next_prog_enable;
      jtag_private_enable <= next_jtag_private;
    end
  end

  // Public instructions never depend on the fuse
  assign jtag_public_enable = 1'b1;

  // ==========================================================
  // Probe multiplexer
  probe_mux u_probe_mux (
    .pclk          (pclk),
    .presetn       (presetn),
    .probe_sel     (probe_sel),
    .internal_nets (internal_nets),
    .security_fuse (security_fuse),
    .small_member  (small_member),
    .probe_pads    (probe_pads),
    .pad_live      (pad_live),
    .pad_blocked   (pad_blocked)
  );

  // Pad outputs
  assign probe_pad_a = probe_pads[0];
  assign probe_pad_b = probe_pads[1];
  assign probe_pad_c = probe_pads[2];
  assign probe_pad_d = probe_pads[3];

  // ==========================================================
  // Checks
  property p_low_power_enter;
    @(posedge pclk) disable iff (!presetn)
      low_power_request |=> low_power_active;
  endproperty
  a_low_power_enter: assert property (p_low_power_enter) else $error("Low power not entered");

  property p_bank_apply;
    @(posedge pclk) disable iff (!presetn)
      low_power_request |=> (bank_output_tristate == $past(cfg_tri)) &&
                            (bank_input_disable == $past(cfg_in));
  endproperty
  a_bank_apply: assert property (p_bank_apply) else $error("Bank choice not applied");

  property p_low_power_exit;
    @(posedge pclk) disable iff (!presetn)
      $fell(low_power_request) |-> ##1 (bank_output_tristate == '0) ##0
                                       (bank_input_disable == '0) ##0 !low_power_active;
  endproperty
  a_low_power_exit: assert property (p_low_power_exit) else $error("Banks not released");

  property p_retain;
    @(posedge pclk) disable iff (!presetn)
      (low_power_request && pwr_state == PWR_RUN && !wr_access &&
       local_clear == '0 && local_preset == '0) |=> $stable(user_state);
  endproperty
  a_retain: assert property (p_retain) else $error("State lost in low power");

  property p_secure;
    @(posedge pclk) disable iff (!presetn)
      security_fuse [*2] |-> (probe_pads == '0) && !programming_enable &&
                            jtag_public_enable;
  endproperty
  a_secure: assert property (p_secure) else $error("Secured part still open");

  property p_pwr_clear;
    @(posedge pclk) disable iff (!presetn)
      (pwr_state == PWR_INIT && !power_up_set_fuse) |=>
        !chip_wide_clear && chip_wide_preset;
  endproperty
  a_pwr_clear: assert property (p_pwr_clear) else $error("Power-up clear wrong");

  property p_pwr_preset;
    @(posedge pclk) disable iff (!presetn)
      (pwr_state == PWR_INIT && power_up_set_fuse) |=>
        chip_wide_clear && !chip_wide_preset ##1 (user_state | $past(local_clear)) != '0;
  endproperty
  a_pwr_preset: assert property (p_pwr_preset) else $error("Power-up preset wrong");

  property p_run_high;
    @(posedge pclk) disable iff (!presetn)
      pwr_state == PWR_RUN |=> chip_wide_clear && chip_wide_preset;
  endproperty
  a_run_high: assert property (p_run_high) else $error("Chip-wide net active");

  property p_local;
    @(posedge pclk) disable iff (!presetn)
      local_clear[0] |=> !user_state[0];
  endproperty
  a_local: assert property (p_local) else $error("Local clear overridden");

  property p_small;
    @(posedge pclk) disable iff (!presetn)
      small_member |=> !probe_pad_c && !probe_pad_d;
  endproperty
  a_small: assert property (p_small) else $error("Upper pads live on small part");

  c_low_power: cover property (@(posedge pclk) disable iff (!presetn) $rose(low_power_active));
  c_preset: cover property (@(posedge pclk) disable iff (!presetn) !chip_wide_preset);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  c_four: cover property (@(posedge pclk) disable iff (!presetn) pad_live == 4'hF);

endmodule

// ===== tb/board_partner.sv
module board_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       low_power_want,
  input  wire logic [3:0] pads,
  output logic            low_power_request,
  output logic [3:0]      probe_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Board pin and probe analyzer
  // Pin stays grounded unless low power is wanted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_request <= 1'b0;
      probe_seen        <= 4'h0;
    end else begin
      low_power_request <= low_power_want;
      probe_seen        <= pads;
    end
  end
endmodule

// ===== tb/tb.sv
module tb
  import lowpower_fuse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Signals
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                low_power_request;
  logic                low_power_want;
  logic                security_fuse;
  logic                power_up_set_fuse;
  logic                small_member;
  logic [USER_W-1:0]   local_clear;
  logic [USER_W-1:0]   local_preset;
  logic [NUM_NETS-1:0] internal_nets;
  logic [7:0]          tri_o;
  logic [7:0]          dis_o;
  logic                clear_net;
  logic                preset_net;
  logic                pa, pb, pc, pd;
  logic [3:0]          pads;
  logic [3:0]          probe_seen;
  logic                prog_en;
  logic                jpub;
  logic                jpriv;
  logic [USER_W-1:0]   user_state;
  logic [31:0]         rd;
  logic                err;
  int                  n_errors;
  int                  check_count;

  assign pads = {pd, pc, pb, pa};

  // Clock at 50 MHz
  always #10 pclk = ~pclk;

  // ==========================================
  // Design and far side
  lowpower_fuse_probe_ctrl u_lowpower_fuse_probe_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_request(low_power_request), .security_fuse(security_fuse),
    .power_up_set_fuse(power_up_set_fuse), .small_member(small_member),
    .local_clear(local_clear), .local_preset(local_preset), .internal_nets(internal_nets),
    .bank_output_tristate(tri_o), .bank_input_disable(dis_o), .chip_wide_clear(clear_net),
    .chip_wide_preset(preset_net), .probe_pad_a(pa), .probe_pad_b(pb), .probe_pad_c(pc),
    .probe_pad_d(pd), .programming_enable(prog_en), .jtag_public_enable(jpub),
    .jtag_private_enable(jpriv), .user_state(user_state)
  );

  board_partner u_board_partner (
    .pclk(pclk), .presetn(presetn), .low_power_want(low_power_want), .pads(pads),
    .low_power_request(low_power_request), .probe_seen(probe_seen)
  );

  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED pready expected 1 seen timeout");
      wrap_up();
    end
  endtask

  // Reset with a chosen set fuse, then check the power-up nets
  task automatic power_up(input logic fuse, input logic [7:0] exp_user, input logic exp_clear);
    @(posedge pclk);
    presetn           <= 1'b0;
    power_up_set_fuse <= fuse;
    settle(20);
    check("reset clear", 1'b0, clear_net);
    check("reset preset", 1'b1, preset_net);
    @(posedge pclk);
    presetn <= 1'b1;
    settle(10);
    check("powerup clear", exp_clear, clear_net);
    check("powerup preset", !exp_clear, preset_net);
    check("powerup user", exp_user, user_state);
    settle(POWER_UP_CYCLES);
    check("run clear", 1'b1, clear_net);
    check("run preset", 1'b1, preset_net);
    $display("test done: power-up with set fuse %0b", fuse);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; low_power_want = 0; security_fuse = 0; power_up_set_fuse = 0;
    small_member = 0; local_clear = 8'h00; local_preset = 8'h02;
    internal_nets = 64'h0; n_errors = 0; check_count = 0;

    power_up(1'b0, 8'h02, 1'b0);
    @(posedge pclk);
    local_preset <= 8'h00;

    // Register access and refusal
    apb(1'b1, ADDR_BANK_CFG, 32'h00000039);
    apb(1'b0, ADDR_BANK_CFG, 32'h0);
    check("bank cfg", 32'h00000039, rd);
    apb(1'b1, ADDR_USER_STATE, 32'h000000A5);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped data", 32'h0, rd);
    check("unmapped err", 1'b1, err);
    $display("test done: register access");

    // Low-power entry and exit
    @(posedge pclk);
    low_power_want <= 1'b1;
    settle(3);
    check("low power tristate", 8'h05, tri_o);
    check("low power in disable", 8'h06, dis_o);
    apb(1'b0, ADDR_USER_STATE, 32'h0);
    check("low power user", 32'h000000A5, rd);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status low power", 1'b1, rd[STAT_LOW_POWER]);
    @(posedge pclk);
    low_power_want <= 1'b0;
    settle(3);
    check("exit tristate", 8'h00, tri_o);
    check("exit in disable", 8'h00, dis_o);
    check("exit user", 8'hA5, user_state);
    $display("test done: low power");

    // Probe routing with a tile over budget
    @(posedge pclk);
    internal_nets <= 64'h00000000001000E0;
    apb(1'b1, ADDR_PROBE_SEL, 32'h94878685);
    settle(4);
    check("probe pads", 4'b1011, probe_seen);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("live blocked", 8'h4B, rd[11:4]);
    check("prog open", 1'b1, prog_en);
    check("private open", 1'b1, jpriv);
    @(posedge pclk);
    small_member <= 1'b1;
    settle(4);
    check("small pads", 4'b0011, probe_seen);
    @(posedge pclk);
    small_member  <= 1'b0;
    security_fuse <= 1'b1;
    settle(4);
    check("secured pads", 4'b0000, probe_seen);
    check("secured prog", 1'b0, prog_en);
    check("public jtag", 1'b1, jpub);
    check("private jtag", 1'b0, jpriv);
    $display("test done: probe");

    // Second reset mid-run with preset fuse and a local clear
    @(posedge pclk);
    security_fuse <= 1'b0;
    local_clear   <= 8'h01;
    power_up(1'b1, 8'hFE, 1'b1);
    wrap_up();
  end
endmodule
